// File: verilog/pcct_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser: the first stage is read only by the second
module pcct_sync #(
    parameter int         W       = 1,
    parameter logic [0:0] RST_VAL = 1'h0
) (
    input  wire logic         mclk,   // system clock
    input  wire logic         srst,   // synchronous reset, active high
    input  wire logic [W-1:0] d,      // asynchronous level
    output logic      [W-1:0] q       // level safe to use in the mclk domain
);

    logic [W-1:0] stage1_r;    // metastability catcher
    logic [W-1:0] stage1_nxt;  // next value of the first stage
    logic [W-1:0] q_r;         // settled level
    logic [W-1:0] q_nxt;       // next value of the second stage

    // next values of both stages
    always_comb begin
        stage1_nxt = d;
        q_nxt      = stage1_r;
    end

    // register both stages
    always_ff @(posedge mclk) begin
        if (srst) begin
            stage1_r <= {W{RST_VAL}};
            q_r      <= {W{RST_VAL}};
        end else begin
            stage1_r <= stage1_nxt;
            q_r      <= q_nxt;
        end
    end

    assign q = q_r;

endmodule

// File: verilog/pcct_timer.sv
// What this block does
// - prescaler and counter advance on falling clock edges
// - reset sets prescaler to all ones, counter zero
// - load reload on first tick and after timeout
// - prescaler tap seven makes a 24-bit chain
// - all-zero counter is the timeout event
// - counter equal to compare value sets flags
// - two selectors choose prescaler and counter clocks
// - masked status flags raise one of seven levels
// - external count clock is synchronised first
// - gate is active low and synchronised first
// - output control field sets initial level, responses
// - mode field 000 selects capture/compare operation
// - enable bits set running flag, then first load
// - shadow copies counter after each tick unless frozen
// - gate rising edge sets flag and freezes shadow
// - gate ignored while gate control is disabled
// - gate level flag always shows synchronised gate
// - gate never stops counting in this mode
// - compare sets event and match flags, drives output
// - timeout sets flag, clears match, drives output
// - output control 01 toggles on each event
// - any enabled set flag asserts the request
`timescale 1ns/1ps
package pcct_pkg;

    localparam logic [7:0]  PRESC_RST   = 8'hFF;    // prescaler after reset
    localparam logic [15:0] CNT_RST     = 16'h0000; // counter after reset
    localparam logic [15:0] SHADOW_RST  = 16'h0000; // shadow after reset
    localparam logic [2:0]  MODE_CAPCMP = 3'h0;     // capture/compare mode code
    localparam logic [1:0]  OC_OFF      = 2'h0;     // output held low
    localparam logic [1:0]  OC_TOGGLE   = 2'h1;     // toggle on each event
    localparam logic [1:0]  OC_ZERO     = 2'h2;     // compare drives low
    localparam logic [1:0]  OC_ONE      = 2'h3;     // compare drives high
    localparam int          MSK_TC      = 0;        // mask bit of compare event
    localparam int          MSK_TG      = 1;        // mask bit of gate event
    localparam int          MSK_TO      = 2;        // mask bit of timeout
    localparam int          IRQ_LEVELS  = 7;        // number of request levels

    // sequencer states, gray coded along idle, arm, count
    typedef enum logic [1:0] {
        PCCT_IDLE  = 2'h0,
        PCCT_ARM   = 2'h1,
        PCCT_COUNT = 2'h3
    } pcct_state_e;

    // control word bits
    typedef struct packed {
        logic       soft_run_bit;           // timer allowed to run
        logic       count_enable_bit;       // prescaler and counter enabled
        logic [2:0] operating_mode_field;   // mode select
        logic [1:0] output_control_field;   // waveform behaviour
        logic       gate_control_enable;    // gate may set the gate event
        logic       ext_clock_select;       // 1: external clock, 0: half mclk
        logic       counter_from_prescaler; // counter runs from prescaler tap
        logic [2:0] prescaler_tap;          // tap n divides by 2**(n+1)
        logic [2:0] irq_mask_field;         // enables of timeout, gate, compare
        logic [2:0] irq_level;              // request level, 0 for none
    } pcct_ctrl_s;

    // status flags
    typedef struct packed {
        logic timeout_flag;       // sticky timeout
        logic gate_event_flag;    // sticky gate event
        logic compare_event_flag; // sticky compare event
        logic gate_level_flag;    // live gate pin level
        logic compare_match_flag; // compare seen since last timeout
        logic running_flag;       // timer enabled
        logic out_level_flag;     // waveform output level
    } pcct_status_s;

    // write-one-to-clear pulses for sticky flags
    typedef struct packed {
        logic timeout_clear;
        logic gate_event_clear;
        logic compare_event_clear;
    } pcct_clear_s;

    // level the output takes while stopped
    function automatic logic pcct_init_level(input logic [1:0] oc);
        return (oc == OC_ZERO);
    endfunction

    // output level after a compare or timeout event
    function automatic logic pcct_event_level(input logic [1:0] oc,
                                              input logic       cur,
                                              input logic       is_cmp);
        logic lvl;
        lvl = cur;
        unique case (oc)
            OC_OFF:    lvl = 1'b0;
            OC_TOGGLE: lvl = ~cur;
            OC_ZERO:   lvl = ~is_cmp;
            OC_ONE:    lvl = is_cmp;
        endcase
        return lvl;
    endfunction

endpackage

// capture/compare timer with prescaler, one clock, loose control ports
module pcct_timer #(
    parameter int IRQ_LEVELS = pcct_pkg::IRQ_LEVELS
) (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic                  ext_count_clock_in,
    input  wire logic                  gate_input_n,
    input  wire pcct_pkg::pcct_ctrl_s  control_word,
    input  wire logic [15:0]           reload_value_one,
    input  wire logic [15:0]           compare_value,
    input  wire pcct_pkg::pcct_clear_s status_clear,
    output logic                       waveform_output,
    output logic [15:0]                counter_shadow,
    output pcct_pkg::pcct_status_s     status_flags,
    output logic [IRQ_LEVELS-1:0]      interrupt_request_levels
);

    logic                   ext_s;        // synchronised external clock
    logic                   gate_s;       // synchronised gate pin level
    pcct_pkg::pcct_state_e  st_r;         // sequencer state
    pcct_pkg::pcct_state_e  st_nxt;
    logic [7:0]             presc_r;      // prescaler
    logic [7:0]             presc_nxt;
    logic [15:0]            cnt_r;        // down-counter
    logic [15:0]            cnt_nxt;
    logic                   half_r;       // half-rate system clock level
    logic                   half_nxt;
    logic                   sel_prev_r;   // selected clock, last cycle
    logic                   sel_prev_nxt;
    logic                   gate_prev_r;  // gate level, last cycle
    logic                   gate_prev_nxt;
    logic                   tick_d_r;     // counter ticked last cycle
    logic                   tick_d_nxt;
    logic [15:0]            shadow_r;     // readable counter copy
    logic [15:0]            shadow_nxt;
    logic                   out_r;        // waveform output
    logic                   out_nxt;
    pcct_pkg::pcct_status_s status_r;     // status flags
    pcct_pkg::pcct_status_s status_nxt;
    logic [IRQ_LEVELS-1:0]  irq_r;        // request lines
    logic [IRQ_LEVELS-1:0]  irq_nxt;
    logic                   enable;       // both run bits set in mode 000
    logic                   sel_lvl;      // selected clock level
    logic                   sel_fall;     // falling edge of selected clock
    logic [7:0]             presc_dec;    // prescaler minus one
    logic                   tap_fall;     // falling edge of prescaler tap
    logic                   ctr_tick;     // counter falling-edge enable
    logic [15:0]            cnt_new;      // counter value after a tick
    logic                   cmp_hit;      // compare event this tick
    logic                   to_hit;       // timeout event this tick
    logic                   tg_set;       // gate event this cycle
    logic                   irq_any;      // some enabled flag is set
    logic                   out_cmp;      // output after the compare step

    // external clock synchroniser
    pcct_sync #(.W(1), .RST_VAL(1'h0)) u_ext_sync (
        .mclk (mclk),
        .srst (srst),
        .d    (ext_count_clock_in),
        .q    (ext_s)
    );

    // gate synchroniser, idles at the negated level
    pcct_sync #(.W(1), .RST_VAL(1'h1)) u_gate_sync (
        .mclk (mclk),
        .srst (srst),
        .d    (gate_input_n),
        .q    (gate_s)
    );

    // clock selection, prescaler, counter, flags, output and requests
    always_comb begin
        // only mode 000 is a running mode of this block
        enable = control_word.soft_run_bit && control_word.count_enable_bit
            && (control_word.operating_mode_field == pcct_pkg::MODE_CAPCMP);
        half_nxt      = ~half_r;
        // first selector: external pin or half system clock
        sel_lvl       = control_word.ext_clock_select ? ext_s : half_r;
        // falling edges become one-cycle enables
        sel_fall      = sel_prev_r && !sel_lvl;
        sel_prev_nxt  = sel_lvl;
        presc_dec     = presc_r - 8'h01;
        // tap bit falling while counting down; tap 7 gives divide by 256
        tap_fall      = (st_r != pcct_pkg::PCCT_IDLE) && sel_fall
            && presc_r[control_word.prescaler_tap]
            && !presc_dec[control_word.prescaler_tap];
        // second selector: selected clock or prescaler output
        ctr_tick      = (st_r != pcct_pkg::PCCT_IDLE)
            && (control_word.counter_from_prescaler ? tap_fall : sel_fall);
        st_nxt        = st_r;
        presc_nxt     = presc_r;
        cnt_nxt       = cnt_r;
        cnt_new       = cnt_r;
        out_nxt       = out_r;
        cmp_hit       = 1'b0;
        to_hit        = 1'b0;
        unique case (st_r)
            // stopped: hold reset values and initial output level
            pcct_pkg::PCCT_IDLE: begin
                presc_nxt = pcct_pkg::PRESC_RST;
                cnt_nxt   = pcct_pkg::CNT_RST;
                out_nxt   = pcct_pkg::pcct_init_level(control_word.output_control_field);
                if (enable) begin
                    st_nxt = pcct_pkg::PCCT_ARM;
                end
            end
            // enabled, waiting for the first counter tick to load
            pcct_pkg::PCCT_ARM: begin
                if (!enable) begin
                    st_nxt = pcct_pkg::PCCT_IDLE;
                end else if (ctr_tick) begin
                    cnt_new = reload_value_one;
                    st_nxt  = pcct_pkg::PCCT_COUNT;
                end
            end
            // counting; the gate has no say here
            pcct_pkg::PCCT_COUNT: begin
                if (!enable) begin
                    st_nxt = pcct_pkg::PCCT_IDLE;
                end else if (ctr_tick) begin
                    // tick after a timeout reloads, otherwise decrement
                    cnt_new = (cnt_r == 16'h0000) ? reload_value_one
                                                  : cnt_r - 16'h0001;
                end
            end
            default: begin
                st_nxt = pcct_pkg::PCCT_IDLE;
            end
        endcase
        // prescaler decrements on selected-clock falls while enabled
        if ((st_r != pcct_pkg::PCCT_IDLE) && enable && sel_fall) begin
            presc_nxt = presc_dec;
        end
        if ((st_r != pcct_pkg::PCCT_IDLE) && enable && ctr_tick) begin
            cnt_nxt = cnt_new;
            cmp_hit = (cnt_new == compare_value);
            to_hit  = (cnt_new == 16'h0000);
        end
        // compare first, timeout last so timeout wins on equal events
        out_cmp = cmp_hit ? pcct_pkg::pcct_event_level(control_word.output_control_field,
                                                       out_r, 1'b1) : out_r;
        if (st_r != pcct_pkg::PCCT_IDLE) begin
            out_nxt = to_hit ? pcct_pkg::pcct_event_level(control_word.output_control_field,
                                                          out_cmp, 1'b0) : out_cmp;
        end
        // gate negation edge, only when gate control is enabled
        gate_prev_nxt = gate_s;
        tg_set        = !gate_prev_r && gate_s && control_word.gate_control_enable
            && (control_word.operating_mode_field == pcct_pkg::MODE_CAPCMP);
        // sticky flags: a set in the clear cycle wins
        status_nxt                    = status_r;
        status_nxt.timeout_flag       = to_hit
            || (status_r.timeout_flag && !status_clear.timeout_clear);
        status_nxt.compare_event_flag = cmp_hit
            || (status_r.compare_event_flag && !status_clear.compare_event_clear);
        status_nxt.gate_event_flag    = tg_set
            || (status_r.gate_event_flag && !status_clear.gate_event_clear);
        if (to_hit) begin
            status_nxt.compare_match_flag = 1'b0;
        end else if (cmp_hit) begin
            status_nxt.compare_match_flag = 1'b1;
        end
        status_nxt.gate_level_flag = gate_s;
        status_nxt.running_flag    = (st_nxt != pcct_pkg::PCCT_IDLE);
        status_nxt.out_level_flag  = out_nxt;
        // shadow follows the counter unless the gate event froze it
        tick_d_nxt = ctr_tick;
        shadow_nxt = shadow_r;
        if (tick_d_r && !status_r.gate_event_flag) begin
            shadow_nxt = cnt_r;
        end
        // masked flags onto the programmed level
        irq_any = |({status_r.timeout_flag, status_r.gate_event_flag,
                     status_r.compare_event_flag} & control_word.irq_mask_field);
        for (int i = 0; i < IRQ_LEVELS; i++) begin
            irq_nxt[i] = irq_any && (control_word.irq_level == 3'(i + 1));
        end
    end

    // register every piece of state
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r        <= pcct_pkg::PCCT_IDLE;
            presc_r     <= pcct_pkg::PRESC_RST;
            cnt_r       <= pcct_pkg::CNT_RST;
            half_r      <= 1'b0;
            sel_prev_r  <= 1'b0;
            gate_prev_r <= 1'b1;
            tick_d_r    <= 1'b0;
            shadow_r    <= pcct_pkg::SHADOW_RST;
            out_r       <= 1'b0;
            status_r    <= '0;
            irq_r       <= '0;
        end else begin
            st_r        <= st_nxt;
            presc_r     <= presc_nxt;
            cnt_r       <= cnt_nxt;
            half_r      <= half_nxt;
            sel_prev_r  <= sel_prev_nxt;
            gate_prev_r <= gate_prev_nxt;
            tick_d_r    <= tick_d_nxt;
            shadow_r    <= shadow_nxt;
            out_r       <= out_nxt;
            status_r    <= status_nxt;
            irq_r       <= irq_nxt;
        end
    end

    assign waveform_output          = out_r;
    assign counter_shadow           = shadow_r;
    assign status_flags             = status_r;
    assign interrupt_request_levels = irq_r;

    // checks on the timer behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_reset_values: assert property ($past(srst) |-> presc_r == pcct_pkg::PRESC_RST
        && cnt_r == pcct_pkg::CNT_RST)
        else $error("prescaler or counter wrong after reset");
    a_presc_on_fall: assert property ((st_r != pcct_pkg::PCCT_IDLE)
        && ($past(st_r) != pcct_pkg::PCCT_IDLE) && $changed(presc_r) |-> $past(sel_fall))
        else $error("prescaler moved without a falling edge");
    a_first_load: assert property ((st_r == pcct_pkg::PCCT_ARM) && enable && ctr_tick
        |=> (cnt_r == $past(reload_value_one)) && (st_r == pcct_pkg::PCCT_COUNT))
        else $error("first tick did not load the reload value");
    a_reload_timeout: assert property ((st_r == pcct_pkg::PCCT_COUNT) && enable
        && ctr_tick && (cnt_r == 16'h0000) |=> cnt_r == $past(reload_value_one))
        else $error("no reload after timeout");
    a_timeout_flags: assert property (to_hit |=> status_r.timeout_flag
        && !status_r.compare_match_flag)
        else $error("timeout flags wrong");
    a_compare_flags: assert property (cmp_hit && !to_hit |=> status_r.compare_event_flag
        && status_r.compare_match_flag)
        else $error("compare flags wrong");
    a_shadow_follow: assert property (tick_d_r && !status_r.gate_event_flag
        |=> counter_shadow == $past(cnt_r))
        else $error("shadow missed the counter");
    a_shadow_frozen: assert property (status_r.gate_event_flag |=> $stable(counter_shadow))
        else $error("shadow moved while frozen");
    a_gate_ignored: assert property (!control_word.gate_control_enable
        && !status_r.gate_event_flag |=> !status_r.gate_event_flag)
        else $error("gate event set with gate control off");
    a_gate_level: assert property (!$past(srst, 1) && !$past(srst, 2) && !$past(srst, 3)
        |-> status_r.gate_level_flag == $past(gate_input_n, 3))
        else $error("gate level flag does not follow the pin");
    a_run_start: assert property (enable && (st_r == pcct_pkg::PCCT_IDLE)
        |=> (st_r == pcct_pkg::PCCT_ARM) && status_r.running_flag)
        else $error("enable did not start the timer");
    a_toggle_out: assert property (to_hit && !cmp_hit
        && (control_word.output_control_field == pcct_pkg::OC_TOGGLE)
        |=> waveform_output != $past(waveform_output))
        else $error("toggle output did not change");
    a_irq_level1: assert property ((control_word.irq_level == 3'h1) && $stable(control_word)
        && status_r.timeout_flag && control_word.irq_mask_field[pcct_pkg::MSK_TO]
        |=> interrupt_request_levels[0])
        else $error("enabled timeout did not raise level one");

    c_timeout: cover property (to_hit);
    c_compare: cover property (cmp_hit && !to_hit);
    c_gate_event: cover property ($rose(status_r.gate_event_flag));
    c_reload: cover property (to_hit ##[1:600] (ctr_tick && st_r == pcct_pkg::PCCT_COUNT));

endmodule

// File: dv/pcct_host_model.sv
`timescale 1ns/1ps
// core-side model: owns the control ports and the clear pulses of the timer
module pcct_host_model (
    input  wire logic             mclk,             // system clock
    output pcct_pkg::pcct_ctrl_s  control_word,     // control bits
    output logic [15:0]           reload_value_one, // reload value
    output logic [15:0]           compare_value,    // compare value
    output pcct_pkg::pcct_clear_s status_clear      // one-cycle clear pulses
);
    // quiet start: stopped, nothing cleared
    initial begin
        control_word     = '0;
        reload_value_one = 16'h0000;
        compare_value    = 16'h0000;
        status_clear     = '0;
    end

    // stop first, change fields while stopped, then apply run bits as asked
    task automatic setup(input pcct_pkg::pcct_ctrl_s c, input logic [15:0] rel, cmp);
        pcct_pkg::pcct_ctrl_s stopped; // new fields with the run bit held off
        stopped = c;
        stopped.soft_run_bit = 1'b0;
        @(negedge mclk);
        control_word.soft_run_bit = 1'b0;
        @(negedge mclk);
        control_word                  = stopped;
        reload_value_one              = rel;
        compare_value                 = cmp;
        @(negedge mclk);
        control_word = c;
    endtask

    // write-one-to-clear pulse, one cycle wide
    task automatic clr(input pcct_pkg::pcct_clear_s c);
        @(negedge mclk);
        status_clear = c;
        @(negedge mclk);
        status_clear = '0;
    endtask
endmodule

// File: dv/prescaled_capture_compare_timer_bench.sv
`timescale 1ns/1ps
// self-checking bench for the capture/compare timer
module prescaled_capture_compare_timer_bench;
    logic                   mclk = 1'b0;   // system clock
    logic                   srst = 1'b1;   // reset
    logic                   ext_in = 1'b0; // external count clock pin
    logic                   gate_n = 1'b0; // gate pin, asserted low
    logic                   ext_run = 1'b0; // lets the external clock run
    int                     ext_div = 0;   // external clock phase counter
    int                     error_cnt = 0; // mismatches
    int                     checks_done = 0; // comparisons made
    int                     n;             // measured interval
    logic [15:0]            s;             // saved shadow
    pcct_pkg::pcct_ctrl_s   cw;            // control word from the host
    logic [15:0]            rel, cmp;      // reload and compare values
    pcct_pkg::pcct_clear_s  sc;            // clear pulses
    logic                   wo;            // waveform output
    logic [15:0]            sh;            // counter shadow
    pcct_pkg::pcct_status_s st;            // status flags
    logic [6:0]             irq;           // request lines

    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    // external clock: 8 mclk period, changed on falling edges
    always @(negedge mclk) begin
        ext_div <= ext_run ? ext_div + 1 : 0;
        if (ext_run && ext_div % 4 == 3) ext_in <= ~ext_in;
    end

    pcct_host_model host (.mclk(mclk), .control_word(cw), .reload_value_one(rel),
        .compare_value(cmp), .status_clear(sc));
    pcct_timer dut (.mclk(mclk), .srst(srst), .ext_count_clock_in(ext_in),
        .gate_input_n(gate_n), .control_word(cw), .reload_value_one(rel),
        .compare_value(cmp), .status_clear(sc), .waveform_output(wo),
        .counter_shadow(sh), .status_flags(st), .interrupt_request_levels(irq));

    // compare seen against expected
    task automatic chk(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // counts and verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // bounded wait for a shadow value
    task automatic ws(input logic [15:0] v);
        for (int i = 0; i < 3000 && sh !== v; i++) @(negedge mclk);
        if (sh !== v) begin
            error_cnt++;
            $display("[ERR] %0t no shadow %h", $time, v);
            close_out();
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    // cycles between two shadow changes
    task automatic meas(output int cnt);
        logic [15:0] p;
        p = sh;
        for (int i = 0; i < 3000 && sh === p; i++) @(negedge mclk);
        p = sh;
        cnt = 0;
        for (int i = 0; i < 3000 && sh === p; i++) begin
            @(negedge mclk);
            cnt++;
        end
        // a shadow that stopped moving ends the run
        if (cnt >= 3000) begin
            error_cnt++;
            $display("[ERR] %0t shadow stopped moving", $time);
            close_out();
        end
    endtask
    // running control word, mode 000
    function automatic pcct_pkg::pcct_ctrl_s mk(input logic [1:0] oc, input logic ge, ex,
                                               fp, input logic [2:0] tap, msk, lvl);
        pcct_pkg::pcct_ctrl_s c;
        c = '0;
        c.soft_run_bit = 1'b1;
        c.count_enable_bit = 1'b1;
        c.operating_mode_field = pcct_pkg::MODE_CAPCMP;
        c.output_control_field = oc;
        c.gate_control_enable = ge;
        c.ext_clock_select = ex;
        c.counter_from_prescaler = fp;
        c.prescaler_tap = tap;
        c.irq_mask_field = msk;
        c.irq_level = lvl;
        return c;
    endfunction

    // stopped: initial output levels and other modes never run
    task automatic t_idle();
        pcct_pkg::pcct_ctrl_s c;
        for (int oc = 0; oc < 4; oc++) begin
            c = mk(oc[1:0], 0, 0, 0, 0, 0, 0);
            c.soft_run_bit = 1'b0;
            host.setup(c, 16'h0005, 16'h0002);
            cyc(3);
            chk(wo, oc == 2);
        end
        for (int m = 1; m < 8; m++) begin
            c = mk(pcct_pkg::OC_TOGGLE, 0, 0, 0, 0, 0, 0);
            c.operating_mode_field = m[2:0];
            host.setup(c, 16'h0005, 16'h0002);
            cyc(20);
            chk(st.running_flag, 1'b0);
            chk(sh, 16'h0000);
        end
        $display("idle test done");
    endtask
    // toggle output, compare, timeout, reload, masked request and its clear
    task automatic t_count();
        host.setup(mk(pcct_pkg::OC_TOGGLE, 0, 0, 0, 0, 3'h1, 3'h3), 16'h0005, 16'h0002);
        cyc(1);
        chk(st.running_flag, 1'b1);
        ws(16'h0005);
        meas(n);
        chk(n, 2);
        ws(16'h0002);
        chk({st.compare_event_flag, st.compare_match_flag}, 2'h3);
        chk({wo, st.out_level_flag}, 2'h3);
        chk(irq, 7'h04);
        ws(16'h0000);
        chk({st.timeout_flag, st.compare_match_flag}, 2'h2);
        chk(wo, 1'b0);
        ws(16'h0005);
        host.clr(3'h5);
        cyc(1);
        chk({st.timeout_flag, st.compare_event_flag, irq}, 9'h000);
        $display("count test done");
    endtask
    // forced-low and forced-high output control: initial level, compare, timeout
    task automatic t_pwm();
        for (int oc = 2; oc < 4; oc++) begin
            host.setup(mk(oc[1:0], 0, 0, 0, 0, 0, 0), 16'h0005, 16'h0002);
            chk(wo, oc == 2);
            ws(16'h0002);
            chk(wo, oc == 3);
            ws(16'h0000);
            chk(wo, oc == 2);
        end
        $display("pwm test done");
    endtask
    // gate freezes the shadow while counting goes on; disabled gate does nothing
    task automatic t_gate();
        host.setup(mk(pcct_pkg::OC_ONE, 1, 0, 0, 0, 3'h2, 3'h1), 16'h0050, 16'h0060);
        ws(16'h0040);
        gate_n = 1'b1;
        cyc(5);
        chk({st.gate_event_flag, st.gate_level_flag, irq}, 9'h181);
        s = sh;
        cyc(20);
        chk(sh, s);
        host.clr(3'h2);
        cyc(2);
        chk(sh < s - 16'h0008, 1'b1);
        host.setup(mk(pcct_pkg::OC_ONE, 0, 0, 0, 0, 3'h2, 3'h1), 16'h0050, 16'h0060);
        gate_n = 1'b0;
        cyc(5);
        chk(st.gate_level_flag, 1'b0);
        gate_n = 1'b1;
        cyc(5);
        chk({st.gate_event_flag, st.gate_level_flag}, 2'h1);
        $display("gate test done");
    endtask
    // prescaler taps and external clock as counter clock
    task automatic t_clk();
        host.setup(mk(pcct_pkg::OC_OFF, 0, 0, 1, 0, 0, 0), 16'h0100, 16'h0000);
        meas(n);
        chk(n, 4);
        host.setup(mk(pcct_pkg::OC_OFF, 0, 0, 1, 7, 0, 0), 16'h0100, 16'h0000);
        meas(n);
        chk(n, 512);
        ext_run = 1'b1;
        host.setup(mk(pcct_pkg::OC_OFF, 0, 1, 0, 0, 0, 0), 16'h0100, 16'h0000);
        meas(n);
        chk(n, 8);
        $display("clock test done");
    endtask

    // main sequence
    initial begin
        repeat (20) @(negedge mclk);
        chk({wo, sh, st, irq}, 31'h0);
        srst = 1'b0;
        cyc(1);
        chk({wo, sh, irq}, 24'h0);
        t_idle();
        t_count();
        t_pwm();
        t_gate();
        t_clk();
        close_out();
    end
endmodule
